// [udma_regs.vh]
// register offsets, field positions, reset values and timing constants of the burst engine
`ifndef UDMA_REGS_VH
`define UDMA_REGS_VH

`define UDMA_ENABLE_OFS 8'h48
`define UDMA_TIMING_OFS 8'h4A
`define UDMA_STATUS_OFS 8'h4C
`define UDMA_FAST_OFS 8'h54

`define UDMA_ENABLE_RST 8'h00
`define UDMA_TIMING_RST 8'h12
`define UDMA_FAST_RST 8'h00

`define UDMA_CT_LSB 0
`define UDMA_CT_MSB 2
`define UDMA_RP_LSB 3
`define UDMA_RP_MSB 5

`define UDMA_SYS_PERIOD_PS 32'h0000_1F40
`define UDMA_PCI_PERIOD_PS 32'h0000_7530
`define UDMA_FAST_PERIOD_PS 32'h0000_3A98
`define UDMA_FAST_CLKS 8'h02
`define UDMA_REDUCED_CLKS 8'h03

`define UDMA_CRC_SEED 16'h4ABA
`define UDMA_CRC_POLY 16'h1021

`define UDMA_ENV_CYCLES 8'h03
`define UDMA_CRC_SETUP_CYCLES 8'h03
`define UDMA_CRC_HOLD_CYCLES 8'h02

`endif

// [udma_engine.v]
// synchronous dma burst engine for one ide channel, host end
`timescale 1ns/1ps
`default_nettype none
`include "udma_regs.vh"

module udma_engine (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_cfg_wr,
  input wire [7:0] i_cfg_addr,
  input wire [7:0] i_cfg_wdata,
  output reg [7:0] o_cfg_rdata,
  input wire i_start,
  input wire i_dir_write,
  input wire [1:0] i_drive_sel,
  input wire i_final_done,
  input wire i_prd_empty,
  input wire i_other_channel_req,
  input wire i_pio_req,
  input wire [1:0] i_pio_cs_n,
  input wire [2:0] i_pio_da,
  input wire [15:0] i_tx_data,
  input wire i_tx_valid,
  output wire o_tx_ready,
  output reg [15:0] o_rx_data,
  output reg o_rx_valid,
  input wire i_rx_ready,
  input wire i_dmarq,
  input wire i_primary_device_strobe_pin,
  input wire [15:0] i_dd,
  output reg [15:0] o_dd,
  output reg o_dd_oe,
  output reg o_dmack_n,
  output reg o_primary_stop_pin,
  output reg o_primary_host_strobe_pin,
  output reg [1:0] o_cs_n,
  output reg [2:0] o_da,
  output wire o_busy
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ACK = 4'h1;
  localparam [3:0] ST_DATA = 4'h2;
  localparam [3:0] ST_RP_WAIT = 4'h3;
  localparam [3:0] ST_STOP_REQ = 4'h4;
  localparam [3:0] ST_STB_HI = 4'h5;
  localparam [3:0] ST_CRC = 4'h6;
  localparam [3:0] ST_RELEASE = 4'h7;

  // clock count at the given period to system cycles, rounded up, never below one
  function [7:0] udma_cycles;
    input [7:0] clks;
    input [31:0] period_ps;
    reg [31:0] t;
    begin
      t = {24'h00_0000, clks} * period_ps + `UDMA_SYS_PERIOD_PS - 32'h0000_0001;
      t = t / `UDMA_SYS_PERIOD_PS;
      if (t == 32'h0000_0000) begin
        t = 32'h0000_0001;
      end
      udma_cycles = t[7:0];
    end
  endfunction

  function [15:0] udma_crc;
    input [15:0] crc;
    input [15:0] data;
    reg [15:0] c;
    integer i;
    begin
      c = crc;
      for (i = 15; i >= 0; i = i - 1) begin
        if (c[15] ^ data[i]) begin
          c = {c[14:0], 1'b0} ^ `UDMA_CRC_POLY;
        end else begin
          c = {c[14:0], 1'b0};
        end
      end
      udma_crc = c;
    end
  endfunction

  reg [7:0] enable_q;
  reg [7:0] timing_q;
  reg [7:0] fast_q;
  reg [3:0] state_q;
  reg [7:0] cnt_q;
  reg [15:0] crc_q;
  reg dir_q;
  reg tx_pend_q;
  reg by_drive_q;
  reg [2:0] dmarq_s_q;
  reg [2:0] dstb_s_q;
  reg [15:0] dd_s1_q;
  reg [15:0] dd_s2_q;
  reg [15:0] dd_s3_q;
  reg dmarq_f_q;
  reg dstb_f_q;

  wire [2:0] ct = timing_q[`UDMA_CT_MSB:`UDMA_CT_LSB];
  wire [2:0] rp = timing_q[`UDMA_RP_MSB:`UDMA_RP_LSB];
  wire fast_sel = fast_q[i_drive_sel];
  wire [7:0] ct_clks = (ct == 3'h0) ? 8'h01 : {5'h00, ct};
  // two clocks per word unless a slower value is programmed
  wire [7:0] fast_clks = (ct <= 3'h2) ? `UDMA_FAST_CLKS : `UDMA_REDUCED_CLKS;
  wire [7:0] hold_cyc = fast_sel ? udma_cycles(fast_clks, `UDMA_FAST_PERIOD_PS) :
                                   udma_cycles(ct_clks, `UDMA_PCI_PERIOD_PS);
  wire [7:0] rp_cyc = udma_cycles({5'h00, rp}, `UDMA_PCI_PERIOD_PS);

  // a pin level counts once the second and third stages agree
  wire dmarq_chg = (dmarq_s_q[1] == dmarq_s_q[2]) && (dmarq_s_q[2] != dmarq_f_q);
  wire dstb_chg = (dstb_s_q[1] == dstb_s_q[2]) && (dstb_s_q[2] != dstb_f_q);
  wire dmarq_lvl = dmarq_chg ? dmarq_s_q[2] : dmarq_f_q;
  // on writes the device strobe pin is the drive's ready, low active
  wire dev_rdy = ~dstb_f_q;
  // host-side reasons to end the burst
  wire term_req = i_other_channel_req | i_pio_req | i_final_done | ~i_start;
  // acknowledge only for an enabled drive with the host ready
  wire start_go = (state_q == ST_IDLE) && dmarq_f_q && i_start && enable_q[i_drive_sel] &&
                  ~i_pio_req && ~i_other_channel_req && ~i_final_done;
  // next word only with drive ready, data present and cycle time met
  wire send_ok = (state_q == ST_DATA) && dir_q && ~tx_pend_q && (cnt_q == 8'h00) &&
                 dev_rdy && i_tx_valid && ~i_prd_empty && ~term_req && dmarq_f_q;
  wire rx_edge = ~dir_q && dstb_chg && ((state_q == ST_DATA) || (state_q == ST_RP_WAIT));

  assign o_tx_ready = send_ok;
  assign o_busy = (state_q != ST_IDLE);

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      dmarq_s_q <= 3'h0;
      dstb_s_q <= 3'h7;
      dd_s1_q <= 16'h0000;
      dd_s2_q <= 16'h0000;
      dd_s3_q <= 16'h0000;
      dmarq_f_q <= 1'b0;
      dstb_f_q <= 1'b1;
    end else begin
      dmarq_s_q <= {dmarq_s_q[1:0], i_dmarq};
      dstb_s_q <= {dstb_s_q[1:0], i_primary_device_strobe_pin};
      dd_s1_q <= i_dd;
      dd_s2_q <= dd_s1_q;
      dd_s3_q <= dd_s2_q;
      dmarq_f_q <= dmarq_lvl;
      if (dstb_chg) begin
        dstb_f_q <= dstb_s_q[2];
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      enable_q <= `UDMA_ENABLE_RST;
      timing_q <= `UDMA_TIMING_RST;
      fast_q <= `UDMA_FAST_RST;
      o_cfg_rdata <= 8'h00;
    end else begin
      if (i_cfg_wr) begin
        case (i_cfg_addr)
          `UDMA_ENABLE_OFS: enable_q <= {4'h0, i_cfg_wdata[3:0]};
          `UDMA_TIMING_OFS: timing_q <= {2'h0, i_cfg_wdata[5:0]};
          `UDMA_FAST_OFS: fast_q <= {4'h0, i_cfg_wdata[3:0]};
          default: ;
        endcase
      end
      case (i_cfg_addr)
        `UDMA_ENABLE_OFS: o_cfg_rdata <= enable_q;
        `UDMA_TIMING_OFS: o_cfg_rdata <= timing_q;
        `UDMA_FAST_OFS: o_cfg_rdata <= fast_q;
        `UDMA_STATUS_OFS: o_cfg_rdata <= {3'h0, by_drive_q, state_q};
        default: o_cfg_rdata <= 8'h00;
      endcase
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      crc_q <= `UDMA_CRC_SEED;
      dir_q <= 1'b0;
      tx_pend_q <= 1'b0;
      by_drive_q <= 1'b0;
      o_rx_data <= 16'h0000;
      o_rx_valid <= 1'b0;
      o_dd <= 16'h0000;
      o_dd_oe <= 1'b0;
      o_dmack_n <= 1'b1;
      o_primary_stop_pin <= 1'b1;
      o_primary_host_strobe_pin <= 1'b1;
      o_cs_n <= 2'h3;
      o_da <= 3'h0;
    end else begin
      o_rx_valid <= 1'b0;
      if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      // chip selects inactive and address low while acknowledged
      if ((state_q == ST_IDLE) && ~start_go) begin
        o_cs_n <= i_pio_cs_n;
        o_da <= i_pio_da;
      end else begin
        o_cs_n <= 2'h3;
        o_da <= 3'h0;
      end
      // every strobed word received enters the crc
      if (rx_edge) begin
        o_rx_data <= dd_s3_q;
        o_rx_valid <= 1'b1;
        crc_q <= udma_crc(crc_q, dd_s3_q);
      end
      case (state_q)
        ST_IDLE: begin
          // idle pins: stop high, acknowledge high, strobe high
          o_primary_stop_pin <= 1'b1;
          o_primary_host_strobe_pin <= 1'b1;
          o_dmack_n <= 1'b1;
          o_dd_oe <= 1'b0;
          tx_pend_q <= 1'b0;
          if (start_go) begin
            o_dmack_n <= 1'b0;
            dir_q <= i_dir_write;
            by_drive_q <= 1'b0;
            crc_q <= `UDMA_CRC_SEED;
            cnt_q <= `UDMA_ENV_CYCLES;
            state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          o_dd_oe <= dir_q;
          if (cnt_q == 8'h00) begin
            // stop dropped; on reads ready asserted only with buffer room and a descriptor
            o_primary_stop_pin <= 1'b0;
            if (~dir_q) begin
              o_primary_host_strobe_pin <= ~(i_rx_ready & ~i_prd_empty);
            end
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (~dmarq_f_q) begin
            // drive ended the burst, acknowledge with stop
            o_primary_stop_pin <= 1'b1;
            o_primary_host_strobe_pin <= dir_q ? o_primary_host_strobe_pin : 1'b1;
            by_drive_q <= 1'b1;
            state_q <= ST_STB_HI;
          end else if (dir_q) begin
            if (send_ok) begin
              o_dd <= i_tx_data;
              tx_pend_q <= 1'b1;
            end else if (tx_pend_q) begin
              // strobe edge after data; word counts in crc only when strobed
              o_primary_host_strobe_pin <= ~o_primary_host_strobe_pin;
              crc_q <= udma_crc(crc_q, o_dd);
              tx_pend_q <= 1'b0;
              cnt_q <= hold_cyc;
            end else if (term_req && (cnt_q == 8'h00)) begin
              o_primary_stop_pin <= 1'b1;
              state_q <= ST_STOP_REQ;
            end
            // no toggle while data or descriptor is missing
          end else begin
            if (term_req) begin
              // ready dropped first, stop after the pause count
              o_primary_host_strobe_pin <= 1'b1;
              cnt_q <= rp_cyc;
              state_q <= ST_RP_WAIT;
            end else begin
              // ready follows buffer room and descriptor count
              o_primary_host_strobe_pin <= ~(i_rx_ready & ~i_prd_empty);
            end
          end
        end
        ST_RP_WAIT: begin
          if (~dmarq_f_q) begin
            o_primary_stop_pin <= 1'b1;
            by_drive_q <= 1'b1;
            state_q <= ST_STB_HI;
          end else if (cnt_q == 8'h00) begin
            o_primary_stop_pin <= 1'b1;
            state_q <= ST_STOP_REQ;
          end
        end
        ST_STOP_REQ: begin
          // wait for the drive to drop its request
          if (~dmarq_f_q) begin
            state_q <= ST_STB_HI;
          end
        end
        ST_STB_HI: begin
          // transmitter strobe back high; not a data edge
          if (dir_q) begin
            if (cnt_q == 8'h00) begin
              o_primary_host_strobe_pin <= 1'b1;
              cnt_q <= `UDMA_CRC_SETUP_CYCLES;
              state_q <= ST_CRC;
            end
          end else if (dstb_f_q) begin
            cnt_q <= `UDMA_CRC_SETUP_CYCLES;
            state_q <= ST_CRC;
          end
        end
        ST_CRC: begin
          // crc on all sixteen lines before acknowledge rises
          o_dd <= crc_q;
          o_dd_oe <= 1'b1;
          if (cnt_q == 8'h00) begin
            o_dmack_n <= 1'b1;
            cnt_q <= `UDMA_CRC_HOLD_CYCLES;
            state_q <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // hold crc past the rising acknowledge so the drive latches it
          if (cnt_q == 8'h00) begin
            o_dd_oe <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [udma_assertions.sv]
// pin-level checker for the dma burst engine
`timescale 1ns/1ps
`default_nettype none
module udma_assertions (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_dir_write,
  input wire logic i_dmarq,
  input wire logic o_dd_oe,
  input wire logic o_dmack_n,
  input wire logic o_primary_stop_pin,
  input wire logic o_primary_host_strobe_pin,
  input wire logic [1:0] o_cs_n,
  input wire logic [2:0] o_da,
  input wire logic o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_idle;
    !o_busy |-> o_primary_stop_pin && o_dmack_n;
  endproperty
  a_idle: assert property (p_idle) else $error("idle pins");
  property p_ack_bus;
    !o_dmack_n |-> o_cs_n == 2'b11 && o_da == 3'b000;
  endproperty
  a_ack_bus: assert property (p_ack_bus) else $error("cs or da active");
  property p_req_first;
    $fell(o_dmack_n) |-> $past(i_dmarq, 3);
  endproperty
  a_req_first: assert property (p_req_first) else $error("ack without request");
  property p_stop_drop;
    $fell(o_dmack_n) |-> ##4 !o_primary_stop_pin;
  endproperty
  a_stop_drop: assert property (p_stop_drop) else $error("stop not dropped");
  property p_rd_start;
    $fell(o_dmack_n) && !i_dir_write |-> !o_dd_oe [*4] ##1 !(o_dd_oe || o_primary_host_strobe_pin);
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read start");
  property p_drv_end;
    $fell(i_dmarq) && !o_dmack_n && !o_primary_stop_pin |-> ##[1:6] o_primary_stop_pin;
  endproperty
  a_drv_end: assert property (p_drv_end) else $error("no stop answer");
  property p_hold;
    !o_dmack_n && i_dir_write && !o_primary_stop_pin && $changed(o_primary_host_strobe_pin)
      |=> $stable(o_primary_host_strobe_pin) [*7];
  endproperty
  a_hold: assert property (p_hold) else $error("strobe too short");
  property p_rp;
    $rose(o_primary_stop_pin) && !o_dmack_n && !i_dir_write && $past(i_dmarq)
      |-> $past(o_primary_host_strobe_pin, 8);
  endproperty
  a_rp: assert property (p_rp) else $error("pause wait short");
  property p_crc_out;
    $rose(o_dmack_n) |-> $past(o_dd_oe) && $past(o_primary_host_strobe_pin) && o_primary_stop_pin;
  endproperty
  a_crc_out: assert property (p_crc_out) else $error("crc phase");
  c_wr: cover property ($fell(o_dmack_n) && i_dir_write);
  c_rd: cover property ($fell(o_dmack_n) && !i_dir_write);
  c_drv: cover property ($fell(i_dmarq) && !o_dmack_n && !o_primary_stop_pin);
endmodule
bind udma_engine udma_assertions u_udma_assertions (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_dir_write(i_dir_write), .i_dmarq(i_dmarq),
  .o_dd_oe(o_dd_oe), .o_dmack_n(o_dmack_n), .o_primary_stop_pin(o_primary_stop_pin),
  .o_primary_host_strobe_pin(o_primary_host_strobe_pin), .o_cs_n(o_cs_n), .o_da(o_da),
  .o_busy(o_busy)
);
`default_nettype wire

// [udma_drive_model.sv]
// behavioural drive answering synchronous dma bursts
`timescale 1ns/1ps
`default_nettype none
module udma_drive_model (
  input wire logic i_dmack_n,
  input wire logic i_stop,
  input wire logic i_hstb,
  input wire logic [15:0] i_dd,
  input wire logic i_go,
  input wire logic i_wr,
  output logic o_dmarq,
  output logic o_dstb,
  output logic [15:0] o_dd,
  output logic [15:0] o_crc
);
  logic [15:0] got [0:7];
  int nw = 0;
  // word on either host strobe edge
  always @(i_hstb) if (!i_dmack_n && !i_stop && i_wr && nw < 8) begin
    got[nw] = i_dd;
    nw++;
  end
  initial begin
    o_dmarq = 0;
    o_dstb = 1;
    o_dd = 16'hFFFF;
    o_crc = 16'h0000;
    forever begin
      @(posedge i_go);
      o_dmarq = 1;
      wait (!i_dmack_n && !i_stop);
      if (i_wr) begin
        // ready low lets the host send
        o_dstb = 0;
        wait (nw == 4);
      end else begin
        wait (!i_hstb);
        // offset keeps pin changes clear of the host clock edge
        #2;
        // word per edge, strobe left high
        for (int k = 0; k < 4; k++) begin
          o_dd = 16'h5000 + 16'(k);
          #16 o_dstb = ~o_dstb;
          #16;
        end
        // released bus must not keep the last word
        o_dd = ~o_dd;
        wait (i_stop);
      end
      o_dmarq = 0;
      @(posedge i_dmack_n) o_crc = i_dd;
      o_dstb = 1;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the dma burst engine
`timescale 1ns/1ps
`default_nettype none
`include "udma_regs.vh"
module tb;
  logic i_sys_clk = 0, i_rst = 1, i_cfg_wr = 0, i_start = 0, i_dir_write = 0;
  logic [7:0] i_cfg_addr = 8'h00, i_cfg_wdata = 8'h00, o_cfg_rdata;
  logic [1:0] i_drive_sel = 2'b00, i_pio_cs_n = 2'b10, o_cs_n;
  logic i_final_done = 0, i_prd_empty = 0, i_other_channel_req = 0, i_pio_req = 0;
  logic [2:0] i_pio_da = 3'b101, o_da;
  logic [15:0] i_tx_data = 16'hA000, o_rx_data, o_dd, m_dd, m_crc;
  logic i_tx_valid = 0, i_rx_ready = 1, m_go = 0, i_dmarq, i_primary_device_strobe_pin;
  logic o_tx_ready, o_rx_valid, o_dd_oe, o_dmack_n, o_primary_stop_pin;
  logic o_primary_host_strobe_pin, o_busy;
  wire [15:0] i_dd = o_dd_oe ? o_dd : m_dd;
  logic [15:0] rx [0:7];
  int error_cnt = 0, num_checks = 0, tx_cnt = 0, rcnt = 0;
  udma_engine u_udma_engine (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_start(i_start),
    .i_dir_write(i_dir_write), .i_drive_sel(i_drive_sel), .i_final_done(i_final_done),
    .i_prd_empty(i_prd_empty), .i_other_channel_req(i_other_channel_req),
    .i_pio_req(i_pio_req), .i_pio_cs_n(i_pio_cs_n), .i_pio_da(i_pio_da),
    .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
    .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
    .i_dmarq(i_dmarq), .i_primary_device_strobe_pin(i_primary_device_strobe_pin),
    .i_dd(i_dd), .o_dd(o_dd), .o_dd_oe(o_dd_oe), .o_dmack_n(o_dmack_n),
    .o_primary_stop_pin(o_primary_stop_pin),
    .o_primary_host_strobe_pin(o_primary_host_strobe_pin), .o_cs_n(o_cs_n), .o_da(o_da),
    .o_busy(o_busy)
  );
  udma_drive_model u_udma_drive_model (.i_dmack_n(o_dmack_n), .i_stop(o_primary_stop_pin),
    .i_hstb(o_primary_host_strobe_pin), .i_dd(i_dd), .i_go(m_go), .i_wr(i_dir_write),
    .o_dmarq(i_dmarq), .o_dstb(i_primary_device_strobe_pin), .o_dd(m_dd), .o_crc(m_crc));
  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_tx_ready === 1'b1) tx_cnt <= tx_cnt + 1;
  always @(negedge i_sys_clk) i_tx_data <= 16'hA000 + tx_cnt[15:0];
  always @(posedge i_sys_clk) if (o_rx_valid === 1'b1 && rcnt < 8) begin
    rx[rcnt] <= o_rx_data;
    rcnt <= rcnt + 1;
  end
  task automatic stop_test;
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // read compares registered data two cycles after the address
  task automatic cfg(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(negedge i_sys_clk);
    i_cfg_addr = a;
    i_cfg_wdata = d;
    i_cfg_wr = wr;
    @(negedge i_sys_clk);
    i_cfg_wr = 0;
    @(negedge i_sys_clk);
    if (!wr) chk({8'h00, o_cfg_rdata}, {8'h00, d});
  endtask
  // expected crc over n words counting up from base, fresh seed per burst
  function automatic logic [15:0] crc_of(input logic [15:0] base, input int n);
    logic [15:0] c;
    logic [15:0] w;
    c = `UDMA_CRC_SEED;
    for (int k = 0; k < n; k++) begin
      w = base + 16'(k);
      for (int b = 15; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? `UDMA_CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction
  task automatic finish_burst;
    logic seen = 0;
    for (int k = 0; k < 3000 && !(seen && !o_busy); k++) begin
      @(negedge i_sys_clk);
      seen |= o_busy;
      if (rcnt == 4) i_final_done = 1;
    end
    chk({14'h0000, seen, o_busy}, 16'h0002);
    i_start = 0;
    m_go = 0;
    i_final_done = 0;
    repeat (4) @(negedge i_sys_clk);
  endtask
  initial begin
    #300us;
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (8) @(negedge i_sys_clk);
    i_rst = 0;
    cfg(`UDMA_ENABLE_OFS, `UDMA_ENABLE_RST, 0);
    cfg(`UDMA_TIMING_OFS, `UDMA_TIMING_RST, 0);
    cfg(`UDMA_FAST_OFS, `UDMA_FAST_RST, 0);
    cfg(`UDMA_FAST_OFS, 8'h0F, 1);
    cfg(`UDMA_FAST_OFS, 8'h0F, 0);
    cfg(`UDMA_FAST_OFS, 8'h00, 1);
    cfg(8'h60, 8'hFF, 1);
    cfg(8'h60, 8'h00, 0);
    chk({11'h000, o_cs_n, o_da}, {11'h000, 2'b10, 3'b101});
    i_dir_write = 1;
    i_tx_valid = 1;
    i_start = 1;
    m_go = 1;
    repeat (30) @(negedge i_sys_clk);
    chk({15'h0000, o_dmack_n}, 16'h0001);
    cfg(`UDMA_ENABLE_OFS, 8'h01, 1);
    finish_burst;
    chk(16'(u_udma_drive_model.nw), 16'h0004);
    for (int k = 0; k < 4; k++) chk(u_udma_drive_model.got[k], 16'hA000 + 16'(k));
    chk(m_crc, crc_of(16'hA000, 4));
    i_dir_write = 0;
    i_start = 1;
    m_go = 1;
    finish_burst;
    chk(16'(rcnt), 16'h0004);
    for (int k = 0; k < 4; k++) chk(rx[k], 16'h5000 + 16'(k));
    chk(m_crc, crc_of(16'h5000, 4));
    stop_test;
  end
endmodule
`default_nettype wire
